/* File: spf_asserts.sv */
// Checker for the serial port core, watching only its ports.
// Assumes the bench keeps the prescale field nonzero during master transfers so each serial half lasts several clocks.
`timescale 1ns/1ps
module spf_checker
  import spf_pkg::*;
#(
  parameter int HALF_UNIT = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic sck_link_i,
  input wire logic sck_o,
  input wire logic sck_oe_n_o,
  input wire logic sdi_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_n_o,
  input wire logic ss_n_i
);
  logic mst, pol, rel, edg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of the control bits, updated where the bus write takes effect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {mst, pol, rel, edg} <= 4'h0;
    end else if (cyc_i && stb_i && we_i && !ack_o && adr_i == SPF_ADR_CTRL) begin
      if (sel_i[SPF_LANE_LO]) begin
        mst <= dat_i[SPF_CTRL_MST];
        pol <= dat_i[SPF_CTRL_POL];
      end
      if (sel_i[SPF_LANE_HI]) begin
        rel <= dat_i[SPF_CTRL_RELEASE];
        edg <= dat_i[SPF_CTRL_EDGE];
      end
    end
  end
  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not acked");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0000_0000) else $error("read data outside ack");
  a_sck_role_drive: assert property (sck_oe_n_o == !$past(mst)) else $error("clock drive wrong for role");
  a_sdo_pin_release: assert property ($past(rel) |-> sdo_oe_n_o) else $error("released output driven");
  a_slave_idle_pol: assert property (!$past(mst) |-> sck_o == $past(pol)) else $error("clock idle level wrong");
  a_sdo_change_edge: assert property ($past(mst) && $changed(sdo_o) && $changed(sck_o)
    |-> sck_o == ($past(edg) ? $past(pol) : !$past(pol))) else $error("data changed on wrong edge");
  a_sck_half_hold: assert property ($past(mst) && $changed(sck_o) |=> $stable(sck_o)) else $error("clock half too short");
  c_bus_write: cover property (ack_o && $past(we_i));
  c_master_clock: cover property (mst && $changed(sck_o));
  c_slave_frame: cover property (!mst && !ss_n_i && !sdo_oe_n_o);
endmodule
bind spf_core spf_checker #(.HALF_UNIT(HALF_UNIT)) chk_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .sck_link_i(sck_link_i), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .sdi_i(sdi_i), .sdo_o(sdo_o),
  .sdo_oe_n_o(sdo_oe_n_o), .ss_n_i(ss_n_i));

/* File: spf_core.sv */
// Function
// (RL1) Release bit frees serial output pin
// (RL2) Width bit selects 16 or 8 bits
// (RL3) Master sample at end or middle
// (RL4) Software keeps sample bit clear in slave
// (RL5) Edge bit picks when output changes
// (RL6) Framed mode ignores edge bit
// (RL7) Slave uses select pin when enabled
// (RL8) Select pin ignored when not enabled
// (RL9) Polarity bit sets idle clock level
// (RL10) Software avoids both prescalers at one
// (RL11) Master bit chooses clock source role
//
// Top of the serial port: Wishbone slave, master shifter, crossing.
// Assumes a 125 MHz clk_i and an unrelated external serial clock.
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module spf_core #(
  parameter int HALF_UNIT = 2,
  parameter int DIV_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic sck_link_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  input wire logic ss_n_i
);
  import spf_pkg::*;

  spf_link_if lk ();

  spf_slave_shift u_slave (
    .sck_link_i(sck_link_i),
    .sdi_i(sdi_i),
    .ss_n_i(ss_n_i),
    .lk(lk)
  );

  logic [11:0] ctrl;
  logic framed;
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic rx_full;
  spf_state_type state;
  logic [DIV_W-1:0] div_cnt;
  logic [5:0] half_idx;
  logic [15:0] m_sh;
  logic [15:0] m_rx;
  logic sdo_m;
  logic [SPF_SYNC_DEPTH-1:0] sdi_sync;
  logic [SPF_SYNC_DEPTH-1:0] ss_sync;
  logic [SPF_SYNC_DEPTH-1:0] tgl_sync;
  logic sdi_m;
  logic ss_n_m;
  logic tgl_seen;

  logic bus_req;
  logic wr_ctrl;
  logic wr_data;
  logic wr_aux;
  logic rd_data;
  logic word16;
  logic eff_edge;
  logic master;
  logic selected;
  logic half_end;
  logic [5:0] last_half;
  logic [5:0] bits2;
  logic toggle_now;
  logic change_now;
  logic sample_now;
  logic sample_mid;
  logic sample_end;
  logic slave_done;
  logic start;
  logic [DIV_W-1:0] half_len;
  logic [15:0] next_m_rx;
  logic [15:0] load_word;
  logic [15:0] next_tx_word;

  // Bus decode; an access is taken in the cycle before ack rises
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr_ctrl = bus_req & we_i & (adr_i == SPF_ADR_CTRL);
  assign wr_data = bus_req & we_i & (adr_i == SPF_ADR_DATA);
  assign wr_aux = bus_req & we_i & (adr_i == SPF_ADR_AUX);
  assign rd_data = bus_req & ~we_i & (adr_i == SPF_ADR_DATA);

  assign word16 = ctrl[SPF_CTRL_WIDTH]; // RL2
  assign master = ctrl[SPF_CTRL_MST]; // RL11
  assign eff_edge = ctrl[SPF_CTRL_EDGE] & ~framed; // RL5 RL6
  assign selected = ctrl[SPF_CTRL_SLAVE_SELECT_ENABLE] & ~ss_n_m; // RL7

  // Half-period length from the prescale field
  assign half_len = DIV_W'((int'(ctrl[SPF_CTRL_PRE_HI:SPF_CTRL_PRE_LO]) + 1) * HALF_UNIT - 1);
  assign half_end = (state == SPF_RUN) && (div_cnt == half_len);

  // Half periods per word; a trailing half is added when data changes on the leading edge
  assign bits2 = word16 ? 6'(2 * SPF_WORD_BITS) : 6'(2 * SPF_BYTE_BITS); // RL2
  assign last_half = eff_edge ? bits2 - 6'h01 : bits2; // RL5

  // Serial clock toggles at the end of each half except the trailing one
  assign toggle_now = half_end && (half_idx < bits2);
  // Output changes on active-to-idle (edge set) or idle-to-active (edge clear)
  always_comb begin
    change_now = 1'b0;
    if (half_end) begin
      if (eff_edge) begin
        change_now = half_idx[0] && (half_idx < last_half); // RL5
      end else begin
        change_now = !half_idx[0] && (half_idx < last_half); // RL5
      end
    end
  end

  // Middle sample: opposite edge; end sample: just before next change
  assign sample_mid = eff_edge ? !half_idx[0] : half_idx[0]; // RL3
  assign sample_end = eff_edge ? half_idx[0] : (!half_idx[0] && half_idx != 6'h00); // RL3
  assign sample_now = half_end && (ctrl[SPF_CTRL_SMP] ? sample_end : sample_mid); // RL3
  assign next_m_rx = sample_now ? {m_rx[14:0], sdi_m} : m_rx;

  // Transmit word as it will stand after this write; the start edge is
  // also the write edge, so the held copy would still show the old word
  assign next_tx_word = {sel_i[SPF_LANE_HI] ? dat_i[15:8] : tx_word[15:8],
                         sel_i[SPF_LANE_LO] ? dat_i[7:0] : tx_word[7:0]};
  // Left-justify so the first bit is always bit 15
  assign load_word = word16 ? next_tx_word : {next_tx_word[7:0], 8'h00}; // RL2
  // A master transfer starts on the edge that takes the data write
  assign start = (state == SPF_IDLE) && master && wr_data;

  // Slave word arrival from the link domain
  assign slave_done = (tgl_sync[2] == tgl_sync[1]) && (tgl_sync[2] != tgl_seen);

  // Configuration and data registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= SPF_CTRL_RESET;
    end else if (wr_ctrl) begin
      if (sel_i[SPF_LANE_LO]) begin
        ctrl[7:0] <= dat_i[7:0];
      end
      if (sel_i[SPF_LANE_HI]) begin
        ctrl[SPF_CTRL_BITS-1:8] <= dat_i[SPF_CTRL_BITS-1:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      framed <= 1'b0;
    end else if (wr_aux && sel_i[SPF_LANE_LO]) begin
      framed <= dat_i[SPF_AUX_FRAMED];
    end
  end

  // Transmit word: refused while a master transfer runs or a slave frame is open
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_word <= 16'h0000;
    end else if (wr_data && state == SPF_IDLE && !selected) begin
      if (sel_i[SPF_LANE_LO]) begin
        tx_word[7:0] <= dat_i[7:0];
      end
      if (sel_i[SPF_LANE_HI]) begin
        tx_word[15:8] <= dat_i[15:8];
      end
    end
  end

  // Receive word and sticky full flag; a new word wins over a read that clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_word <= 16'h0000;
      rx_full <= 1'b0;
    end else if (half_end && half_idx == last_half) begin
      rx_word <= next_m_rx;
      rx_full <= 1'b1;
    end else if (slave_done && !master) begin
      rx_word <= lk.rx_word;
      rx_full <= 1'b1;
    end else if (rd_data) begin
      rx_full <= 1'b0;
    end
  end

  // Master sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= SPF_IDLE;
      div_cnt <= '0;
      half_idx <= 6'h00;
    end else begin
      unique case (state)
        SPF_IDLE: begin
          div_cnt <= '0;
          half_idx <= 6'h00;
          if (start) begin
            state <= SPF_RUN; // RL11
          end
        end
        SPF_RUN: begin
          if (half_end) begin
            div_cnt <= '0;
            half_idx <= half_idx + 6'h01;
            if (half_idx == last_half) begin
              state <= SPF_IDLE;
            end
          end else begin
            div_cnt <= div_cnt + DIV_W'(1);
          end
        end
      endcase
    end
  end

  // Master shift registers and serial data out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_sh <= 16'h0000;
      m_rx <= 16'h0000;
      sdo_m <= 1'b0;
    end else if (start) begin
      m_rx <= 16'h0000;
      if (eff_edge) begin
        sdo_m <= load_word[15]; // RL5
        m_sh <= {load_word[14:0], 1'b0};
      end else begin
        m_sh <= load_word;
      end
    end else begin
      m_rx <= next_m_rx;
      if (change_now) begin
        sdo_m <= m_sh[15]; // RL5
        m_sh <= {m_sh[14:0], 1'b0};
      end
    end
  end

  // Serial clock: idles at polarity level, driven only as master
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_o <= 1'b0;
      sck_oe_n_o <= 1'b1;
    end else begin
      sck_oe_n_o <= ~master; // RL11
      if (state == SPF_IDLE) begin
        sck_o <= ctrl[SPF_CTRL_POL]; // RL9
      end else if (toggle_now) begin
        sck_o <= ~sck_o; // RL9
      end
    end
  end

  // Data pin drive: released by software, or as an unselected slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_oe_n_o <= 1'b1;
    end else begin
      sdo_oe_n_o <= ctrl[SPF_CTRL_RELEASE] | (~master & ctrl[SPF_CTRL_SLAVE_SELECT_ENABLE] & ss_n_m); // RL1 RL7 RL8
    end
  end

  // Master input lags the pin by four clocks, so a serial half must last longer
  // Pin and toggle synchronisers; only the last two stages are compared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdi_sync <= '0;
      ss_sync <= '1;
      tgl_sync <= '0;
      sdi_m <= 1'b0;
      ss_n_m <= 1'b1;
      tgl_seen <= 1'b0;
    end else begin
      sdi_sync <= {sdi_sync[1:0], sdi_i};
      ss_sync <= {ss_sync[1:0], ss_n_i};
      tgl_sync <= {tgl_sync[1:0], lk.done_tgl};
      if (sdi_sync[2] == sdi_sync[1]) begin
        sdi_m <= sdi_sync[2];
      end
      if (ss_sync[2] == ss_sync[1]) begin
        ss_n_m <= ss_sync[2]; // RL7
      end
      if (tgl_sync[2] == tgl_sync[1]) begin
        tgl_seen <= tgl_sync[2];
      end
    end
  end

  // Link-side configuration; software changes it only between frames
  // Link logic takes these as static levels, so none may move inside a frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lk.tx_hold <= 16'h0000;
      lk.word16 <= 1'b0;
      lk.sample_inv <= 1'b1;
      lk.slave_select_enable <= 1'b0;
      lk.master <= 1'b1;
      lk.link_rst <= 1'b1;
    end else begin
      lk.tx_hold <= tx_word;
      lk.word16 <= word16; // RL2
      lk.sample_inv <= ~(ctrl[SPF_CTRL_POL] ^ eff_edge); // RL4 RL5 RL9
      lk.slave_select_enable <= ctrl[SPF_CTRL_SLAVE_SELECT_ENABLE]; // RL7 RL8
      lk.master <= master; // RL11
      lk.link_rst <= 1'b0;
    end
  end

  // Wishbone answer: one-cycle ack, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      dat_o <= 32'h0000_0000;
      if (bus_req && !we_i) begin
        unique case (adr_i)
          SPF_ADR_CTRL: dat_o <= {20'h0_0000, ctrl};
          SPF_ADR_DATA: dat_o <= {16'h0000, rx_word};
          SPF_ADR_STAT: begin
            dat_o[SPF_STAT_SEL] <= selected;
            dat_o[SPF_STAT_FULL] <= rx_full;
            dat_o[SPF_STAT_BUSY] <= (state == SPF_RUN);
          end
          SPF_ADR_AUX: dat_o[SPF_AUX_FRAMED] <= framed;
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Pin data: master shifter or link-clocked slave shifter
  assign sdo_o = master ? sdo_m : lk.sdo_s; // RL11
endmodule

/* File: spf_link_if.sv */
// Carrier between the bus-side core and the link-clocked slave shifter.
// Assumes core fields only change while no slave frame is in progress.
`timescale 1ns/1ps
interface spf_link_if;
  logic [15:0] tx_hold;
  logic word16;
  logic sample_inv;
  logic slave_select_enable;
  logic master;
  logic link_rst;
  logic [15:0] rx_word;
  logic done_tgl;
  logic sdo_s;
  modport core (output tx_hold, word16, sample_inv, slave_select_enable, master, link_rst,
                input rx_word, done_tgl, sdo_s);
  modport link (input tx_hold, word16, sample_inv, slave_select_enable, master, link_rst,
                output rx_word, done_tgl, sdo_s);
endinterface

/* File: spf_partner.sv */
// Behavioural far-side serial device answering the core in master role.
// Assumes the bench pulses load_i after each configuration change.
`timescale 1ns/1ps
module spf_partner (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic pol_i,
  input wire logic edge_i,
  input wire logic w16_i,
  input wire logic load_i,
  input wire logic [15:0] tx_i,
  output logic miso_o,
  output logic [15:0] rx_o
);
  logic ob;
  logic gone;
  int ptr;
  // Once the last bit has been held for its full time the line shows the inverse
  assign miso_o = gone ? ~ob : ob;
  always @(posedge load_i) begin
    rx_o = 16'h0000;
    gone = 1'b0;
    ptr = w16_i ? 15 : 7;
    if (edge_i) begin
      ob = tx_i[ptr];
      ptr--;
    end
  end
  // Change on one clock transition, sample on the other
  always @(sck_i) begin
    if ((sck_i == pol_i) == edge_i) begin
      if (ptr >= 0) begin
        ob = tx_i[ptr];
      end else begin
        gone = 1'b1;
      end
      ptr--;
    end else begin
      rx_o = {rx_o[14:0], mosi_i};
    end
  end
endmodule

/* File: spf_pkg.sv */
// Shared constants and types for the serial port frame-format block.
// Assumes a 32-bit classic Wishbone slave and a 12-bit control register.
package spf_pkg;
  // Register byte addresses
  localparam logic [7:0] SPF_ADR_CTRL = 8'h00;
  localparam logic [7:0] SPF_ADR_DATA = 8'h04;
  localparam logic [7:0] SPF_ADR_STAT = 8'h08;
  localparam logic [7:0] SPF_ADR_AUX = 8'h0C;
  // Control register fields
  localparam int SPF_CTRL_BITS = 12;
  localparam int SPF_CTRL_RELEASE = 11;
  localparam int SPF_CTRL_WIDTH = 10;
  localparam int SPF_CTRL_SMP = 9;
  localparam int SPF_CTRL_EDGE = 8;
  localparam int SPF_CTRL_SLAVE_SELECT_ENABLE = 7;
  localparam int SPF_CTRL_POL = 6;
  localparam int SPF_CTRL_MST = 5;
  localparam int SPF_CTRL_PRE_HI = 4;
  localparam int SPF_CTRL_PRE_LO = 0;
  localparam logic [11:0] SPF_CTRL_RESET = 12'h000;
  // Status and auxiliary fields
  localparam int SPF_STAT_SEL = 0;
  localparam int SPF_STAT_FULL = 1;
  localparam int SPF_STAT_BUSY = 2;
  localparam int SPF_AUX_FRAMED = 0;
  // Transfer sizes
  localparam int SPF_WORD_BITS = 16;
  localparam int SPF_BYTE_BITS = 8;
  localparam logic [3:0] SPF_LAST_WORD = 4'hF;
  localparam logic [3:0] SPF_LAST_BYTE = 4'h7;
  // Byte lanes
  localparam int SPF_LANE_LO = 0;
  localparam int SPF_LANE_HI = 1;
  // Synchroniser depth
  localparam int SPF_SYNC_DEPTH = 3;
  typedef enum logic [1:0] {
    SPF_IDLE = 2'b01,
    SPF_RUN = 2'b10
  } spf_state_type;
endpackage

/* File: spf_slave_shift.sv */
// Slave-role shifter clocked by the external serial clock.
// Assumes configuration in the carrier is static during a frame.
`timescale 1ns/1ps
module spf_slave_shift (
  input wire logic sck_link_i,
  input wire logic sdi_i,
  input wire logic ss_n_i,
  spf_link_if.link lk
);
  import spf_pkg::*;
  logic clk_s;
  logic frame_rst;
  logic [3:0] cnt;
  logic [3:0] idx;
  logic [15:0] sh;
  logic [3:0] last;

  // Edge choice is static while a frame runs, so the xor cannot glitch mid-frame
  assign clk_s = sck_link_i ^ lk.sample_inv; // RL5 RL9
  // Frame boundary from the select pin only when enabled
  assign frame_rst = lk.master | (lk.slave_select_enable & ss_n_i); // RL7 RL8 RL11
  assign last = lk.word16 ? SPF_LAST_WORD : SPF_LAST_BYTE; // RL2

  always_ff @(posedge clk_s or posedge frame_rst) begin
    if (frame_rst) begin
      cnt <= 4'h0;
      sh <= 16'h0000;
    end else begin
      sh <= {sh[14:0], sdi_i};
      cnt <= (cnt == last) ? 4'h0 : cnt + 4'h1; // RL2
    end
  end

  always_ff @(posedge clk_s or posedge lk.link_rst) begin
    if (lk.link_rst) begin
      lk.done_tgl <= 1'b0;
      lk.rx_word <= 16'h0000;
    end else if (!frame_rst && cnt == last) begin
      lk.rx_word <= {sh[14:0], sdi_i};
      lk.done_tgl <= ~lk.done_tgl;
    end
  end

  // Output bit index moves on the change edge
  always_ff @(negedge clk_s or posedge frame_rst) begin
    if (frame_rst) begin
      idx <= 4'h0;
    end else begin
      idx <= cnt; // RL5
    end
  end

  assign lk.sdo_s = lk.tx_hold[last - idx];
endmodule

/* File: test_spi_frame_format_config.sv */
// Self-checking bench: register table, master transfers, slave frames, reset.
// Assumes the core answers each Wishbone request one cycle after it is taken.
`timescale 1ns/1ps
module test_spi_frame_format_config;
  import spf_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] ex; logic sck; logic soe; logic doe;} spf_row_type;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ss_n_i = 1, sck_link_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, rd, mask;
  logic ack_o, sck_o, sck_oe_n_o, sdo_o, sdo_oe_n_o, sdi_i, miso, sck_w, sdo_w;
  logic tb_drv = 0, tb_sdi = 0, ld = 0, p_pol = 0, p_edge = 0, p_w16 = 0;
  logic [15:0] p_rx;
  logic [7:0] got;
  logic [11:0] cfg [4] = '{12'h122, 12'h562, 12'h062, 12'h622};
  spf_row_type rows [4] = '{'{8'h00, 32'hFFFF_F800, 32'h0000_0800, 0, 1, 1},
    '{8'h00, 32'h0000_0821, 32'h0000_0821, 0, 0, 1}, '{8'h00, 32'h0000_0061, 32'h0000_0061, 1, 0, 0},
    '{8'h10, 32'hDEAD_BEEF, 32'h0000_0000, 1, 0, 0}};
  int miscompares = 0, num_checks = 0;
  assign sck_w = sck_oe_n_o ? sck_link_i : sck_o;
  // Pull-up on the data line when nobody drives it
  assign sdo_w = sdo_oe_n_o ? 1'b1 : sdo_o;
  assign sdi_i = tb_drv ? tb_sdi : miso;
  always #4 clk_i = ~clk_i;
  spf_core #(.HALF_UNIT(2), .DIV_W(8)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sck_link_i(sck_link_i), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .sdi_i(sdi_i), .sdo_o(sdo_o),
    .sdo_oe_n_o(sdo_oe_n_o), .ss_n_i(ss_n_i));
  spf_partner peer (.sck_i(sck_w), .mosi_i(sdo_w), .pol_i(p_pol), .edge_i(p_edge), .w16_i(p_w16),
    .load_i(ld), .tx_i(16'h3C96), .miso_o(miso), .rx_o(p_rx));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i} <= {1'b1, 1'b1, w, 4'h3};
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 20);
    if (t >= 20) miscompares++;
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic frame(input logic [7:0] b);
    #1.3;
    for (int i = 7; i >= 0; i--) begin
      tb_sdi = b[i];
      #3 sck_link_i = 1;
      got = {got[6:0], sdo_w};
      #3 sck_link_i = 0;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    foreach (rows[i]) begin
      wb(1, rows[i].a, rows[i].wd);
      wb(0, rows[i].a, 32'h0000_0000);
      chk("reg", rd, rows[i].ex);
      repeat (2) @(posedge clk_i);
      chk("sck", sck_o, rows[i].sck);
      chk("sck_oe", sck_oe_n_o, rows[i].soe);
      chk("sdo_oe", sdo_oe_n_o, rows[i].doe);
    end
    $display("register table done");
    foreach (cfg[i]) begin
      wb(1, SPF_ADR_CTRL, {20'h0_0000, cfg[i]});
      // Let the idle clock settle at its new level before the peer arms
      repeat (2) @(posedge clk_i);
      {p_w16, p_edge, p_pol} = {cfg[i][SPF_CTRL_WIDTH], cfg[i][SPF_CTRL_EDGE], cfg[i][SPF_CTRL_POL]};
      mask = p_w16 ? 32'h0000_FFFF : 32'h0000_00FF;
      ld = 1;
      #1 ld = 0;
      wb(1, SPF_ADR_DATA, 32'h0000_A55A);
      for (int t = 0; t < 200; t++) begin
        wb(0, SPF_ADR_STAT, 32'h0000_0000);
        if (rd[SPF_STAT_BUSY] === 1'b0) break;
      end
      chk("full", rd[SPF_STAT_FULL], 1);
      wb(0, SPF_ADR_DATA, 32'h0000_0000);
      chk("rx", rd & mask, 32'h0000_3C96 & mask);
      chk("peer", {16'h0000, p_rx} & mask, 32'h0000_A55A & mask);
      wb(0, SPF_ADR_STAT, 32'h0000_0000);
      chk("full clr", rd[SPF_STAT_FULL], 0);
    end
    $display("master transfers done");
    wb(1, SPF_ADR_CTRL, 32'h0000_0180);
    wb(1, SPF_ADR_DATA, 32'h0000_00C3);
    tb_drv = 1;
    ss_n_i <= 0;
    repeat (6) @(posedge clk_i);
    frame(8'h6B);
    chk("slave out", got, 8'hC3);
    @(posedge clk_i);
    ss_n_i <= 1;
    repeat (10) @(posedge clk_i);
    wb(0, SPF_ADR_STAT, 32'h0000_0000);
    chk("slave full", rd[SPF_STAT_FULL], 1);
    wb(0, SPF_ADR_DATA, 32'h0000_0000);
    chk("slave rx", rd & 32'h0000_00FF, 32'h0000_006B);
    wb(1, SPF_ADR_CTRL, 32'h0000_0100);
    frame(8'h2D);
    chk("no select out", got, 8'hC3);
    repeat (10) @(posedge clk_i);
    wb(0, SPF_ADR_DATA, 32'h0000_0000);
    chk("no select", rd & 32'h0000_00FF, 32'h0000_002D);
    $display("slave frames done");
    wb(1, SPF_ADR_CTRL, 32'h0000_0821);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    #1;
    chk("rst sck_oe", sck_oe_n_o, 1);
    chk("rst sdo_oe", sdo_oe_n_o, 0);
    wb(0, SPF_ADR_CTRL, 32'h0000_0000);
    chk("rst ctrl", rd, {20'h0_0000, SPF_CTRL_RESET});
    $display("reset done");
    end_sim;
  end
endmodule
